// >>> fac_classifier.sv
`timescale 1ns/1ps
// Notes on behaviour
// - scope is any, one port, or policy
// - frame type any, ethertype, arp, ipv4
// - deny hit drops the frame
// - permit hit forwards normally with actions
// - rate limiter disabled or index 1-15
// - port copy duplicates to named port
// - enabled logging reports hits, rate limited
// - shutdown hit disables the ingress port
// - one hit counter per entry
// - source filter only for ethertype, arp
// - source any or exact six octets
// - destination any, group, all, single class
// - destination specific needs exact match
// - vlan specific must equal 1-4095 value
// - vlan any is don't care
// - priority don't care or exact 0-7
// - storage for 128 entries
module fac_classifier
(
  // clock and reset
  input logic clock,
  input logic rst,
  // register port
  input logic [fac_pkg::ADDR_W-1:0] regAddr,
  input logic [31:0] regWdata,
  input logic regWrite,
  input logic regRead,
  output logic [31:0] regRdata,
  // frame from receive path
  input logic frmValid,
  output logic frmReady,
  input fac_pkg::fac_frame_s frm,
  // verdict to forwarding
  output logic resValid,
  output fac_pkg::fac_result_s res,
  // log path
  output logic logValid,
  output logic [fac_pkg::IDX_W-1:0] logIndex,
  // port state and interrupt
  output logic [fac_pkg::NUM_PORTS-1:0] portShut,
  output logic irq
);
  // ==========================================
  // declarations
  fac_pkg::fac_state_e state;
  fac_pkg::fac_state_e next_state;
  fac_pkg::fac_words_t stage;
  fac_pkg::fac_entry_s entries [fac_pkg::NUM_ENTRIES];
  fac_pkg::fac_entry_s scanEntry;
  fac_pkg::fac_frame_s frame;
  logic [fac_pkg::NUM_ENTRIES-1:0] entValid;
  logic [fac_pkg::IDX_W-1:0] entrySel;
  logic [fac_pkg::IDX_W-1:0] scanIdx;
  logic [fac_pkg::CNT_W-1:0] selCount;
  logic [fac_pkg::INT_W-1:0] intStat;
  logic [fac_pkg::INT_W-1:0] intMask;
  logic [fac_pkg::INT_W-1:0] intSet;
  logic [fac_pkg::GAP_W-1:0] logGap;
  logic [fac_pkg::IDX_W:0] lastInfo;
  logic scanHit;
  logic hitNow;
  logic lastIdx;
  logic wrCtrl;
  logic doCommit;
  logic doLoad;
  logic doClrCnt;
  logic doRemoveAll;
  logic logWant;
  logic logGo;
  logic [3:0] wrSlot;
  logic [3:0] rdSlot;

  // ==========================================
  // decode helpers
  function automatic logic [3:0] cfg_slot(input logic [fac_pkg::ADDR_W-1:0] a);
    logic [fac_pkg::ADDR_W-1:0] d;
    d = a - fac_pkg::OFF_CFG0;
    if (a >= fac_pkg::OFF_CFG0 && d[1:0] == 2'h0 && d[7:2] < 6'(fac_pkg::NUM_CFG))
      return d[5:2];
    return 4'hf;
  endfunction

  function automatic fac_pkg::fac_entry_s unpack_words(input fac_pkg::fac_words_t w);
    fac_pkg::fac_entry_s e;
    e.scope = fac_pkg::fac_scope_e'(w[0][fac_pkg::POS_SCOPE +: 2]);
    e.scopeVal = w[0][fac_pkg::POS_SCOPE_VAL +: fac_pkg::PORT_W];
    e.ftype = fac_pkg::fac_ftype_e'(w[0][fac_pkg::POS_FTYPE +: 2]);
    e.deny = w[0][fac_pkg::POS_DENY];
    e.rateSel = w[0][fac_pkg::POS_RATE +: 4];
    e.copyEn = w[0][fac_pkg::POS_COPY_EN];
    e.copyPort = w[0][fac_pkg::POS_COPY_PORT +: fac_pkg::PORT_W];
    e.logEn = w[0][fac_pkg::POS_LOG];
    e.shutEn = w[0][fac_pkg::POS_SHUT];
    e.srcSpecific = w[0][fac_pkg::POS_SRC_SPEC];
    e.dstFilter = fac_pkg::fac_dafilt_e'(w[0][fac_pkg::POS_DST_FILT +: 3]);
    e.vlanSpecific = w[0][fac_pkg::POS_VLAN_SPEC];
    e.prioAny = w[0][fac_pkg::POS_PRIO_ANY];
    e.prio = w[0][fac_pkg::POS_PRIO +: 3];
    e.vid = w[1][fac_pkg::POS_VID +: 12];
    e.sourceStationAddress = {w[3][15:0], w[2]};
    e.destinationStationAddress = {w[5][15:0], w[4]};
    return e;
  endfunction

  function automatic fac_pkg::fac_words_t pack_entry(input fac_pkg::fac_entry_s e, input logic v);
    fac_pkg::fac_words_t w;
    w = '0;
    w[0][fac_pkg::POS_VALID] = v;
    w[0][fac_pkg::POS_SCOPE +: 2] = e.scope;
    w[0][fac_pkg::POS_SCOPE_VAL +: fac_pkg::PORT_W] = e.scopeVal;
    w[0][fac_pkg::POS_FTYPE +: 2] = e.ftype;
    w[0][fac_pkg::POS_DENY] = e.deny;
    w[0][fac_pkg::POS_RATE +: 4] = e.rateSel;
    w[0][fac_pkg::POS_COPY_EN] = e.copyEn;
    w[0][fac_pkg::POS_COPY_PORT +: fac_pkg::PORT_W] = e.copyPort;
    w[0][fac_pkg::POS_LOG] = e.logEn;
    w[0][fac_pkg::POS_SHUT] = e.shutEn;
    w[0][fac_pkg::POS_SRC_SPEC] = e.srcSpecific;
    w[0][fac_pkg::POS_DST_FILT +: 3] = e.dstFilter;
    w[0][fac_pkg::POS_VLAN_SPEC] = e.vlanSpecific;
    w[0][fac_pkg::POS_PRIO_ANY] = e.prioAny;
    w[0][fac_pkg::POS_PRIO +: 3] = e.prio;
    w[1][fac_pkg::POS_VID +: 12] = e.vid;
    w[2] = e.sourceStationAddress[31:0];
    w[3][15:0] = e.sourceStationAddress[47:32];
    w[4] = e.destinationStationAddress[31:0];
    w[5][15:0] = e.destinationStationAddress[47:32];
    return w;
  endfunction

  // ==========================================
  // control strobes
  assign wrCtrl = regWrite && regAddr == fac_pkg::OFF_CTRL;
  assign doCommit = wrCtrl && regWdata[fac_pkg::CTRL_COMMIT];
  assign doLoad = wrCtrl && regWdata[fac_pkg::CTRL_LOAD];
  assign doClrCnt = wrCtrl && regWdata[fac_pkg::CTRL_CLR_CNT];
  assign doRemoveAll = wrCtrl && regWdata[fac_pkg::CTRL_REMOVE_ALL];
  assign wrSlot = regWrite ? cfg_slot(regAddr) : 4'hf;
  assign rdSlot = cfg_slot(regAddr);

  // ==========================================
  // entry storage
  // table of 128 entries
  always_ff @(posedge clock)
  begin
    if (doCommit)
      entries[entrySel] <= unpack_words(stage);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      entValid <= '0;
    else if (doRemoveAll)
      entValid <= '0;
    else if (doCommit)
      entValid[entrySel] <= stage[0][fac_pkg::POS_VALID];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      entrySel <= fac_pkg::RST_SEL;
    else if (regWrite && regAddr == fac_pkg::OFF_SEL)
      entrySel <= regWdata[fac_pkg::IDX_W-1:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stage <= {fac_pkg::NUM_CFG{fac_pkg::RST_CFG}};
    else if (doLoad)
      stage <= pack_entry(entries[entrySel], entValid[entrySel]);
    else if (wrSlot != 4'hf)
      stage[wrSlot[2:0]] <= regWdata;
  end

  // ==========================================
  // scan sequencer
  assign scanEntry = entries[scanIdx];
  assign lastIdx = scanIdx == fac_pkg::IDX_W'(fac_pkg::NUM_ENTRIES - 1);
  assign hitNow = state == fac_pkg::FAC_ST_SCAN && scanHit;
  assign frmReady = state == fac_pkg::FAC_ST_IDLE;
  assign resValid = state == fac_pkg::FAC_ST_DONE;

  fac_entry_match uMatch
  (
    .valid(entValid[scanIdx]),
    .entry(scanEntry),
    .frame(frame),
    .hit(scanHit)
  );

  always_comb
  begin
    case (state)
      fac_pkg::FAC_ST_IDLE: next_state = frmValid ? fac_pkg::FAC_ST_SCAN : fac_pkg::FAC_ST_IDLE;
      fac_pkg::FAC_ST_SCAN: next_state = (scanHit || lastIdx) ? fac_pkg::FAC_ST_DONE : fac_pkg::FAC_ST_SCAN;
      fac_pkg::FAC_ST_DONE: next_state = fac_pkg::FAC_ST_IDLE;
      default: next_state = fac_pkg::FAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= fac_pkg::FAC_ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      frame <= '0;
    else if (frmValid && frmReady)
      frame <= frm;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      scanIdx <= '0;
    else if (state != fac_pkg::FAC_ST_SCAN)
      scanIdx <= '0;
    else if (!scanHit && !lastIdx)
      scanIdx <= scanIdx + 7'h1;
  end

  // ==========================================
  // verdict
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      res <= '0;
    else if (hitNow)
    begin
      res.hit <= 1'b1;
      res.index <= scanIdx;
      res.drop <= scanEntry.deny;
      res.rateSel <= scanEntry.rateSel;
      res.copyEn <= scanEntry.copyEn;
      res.copyPort <= scanEntry.copyPort;
      res.log <= scanEntry.logEn;
      res.shut <= scanEntry.shutEn;
      res.port <= frame.port;
    end
    else if (state == fac_pkg::FAC_ST_SCAN && lastIdx)
    begin
      res <= '0;
      res.port <= frame.port;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      lastInfo <= '0;
    else if (state == fac_pkg::FAC_ST_SCAN && (scanHit || lastIdx))
      lastInfo <= {scanHit, scanIdx};
  end

  // ==========================================
  // hit counters
  // only the winning entry counts
  fac_hit_count uCount
  (
    .clock(clock),
    .rst(rst),
    .incEn(hitNow),
    .incIdx(scanIdx),
    .clrAll(doClrCnt),
    .rdIdx(entrySel),
    .rdCount(selCount)
  );

  // ==========================================
  // log path with spacing
  assign logWant = hitNow && scanEntry.logEn;
  assign logGo = logWant && logGap == '0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      logGap <= '0;
    else if (logGo)
      logGap <= fac_pkg::GAP_W'(fac_pkg::LOG_GAP_CYC - 1);
    else if (logGap != '0)
      logGap <= logGap - 11'h1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      logValid <= 1'b0;
      logIndex <= '0;
    end
    else
    begin
      logValid <= logGo;
      if (logGo)
        logIndex <= scanIdx;
    end
  end

  // ==========================================
  // port shutdown, set wins over clear
  // disable ingress port
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      portShut <= '0;
    else
    begin
      for (int p = 0; p < fac_pkg::NUM_PORTS; p++)
      begin
        if (hitNow && scanEntry.shutEn && frame.port == p[fac_pkg::PORT_W-1:0])
          portShut[p] <= 1'b1;
        else if (regWrite && regAddr == fac_pkg::OFF_PORT_SHUT && regWdata[p])
          portShut[p] <= 1'b0;
      end
    end
  end

  // ==========================================
  // interrupts
  always_comb
  begin
    intSet = '0;
    intSet[fac_pkg::INT_LOGGED] = logGo;
    intSet[fac_pkg::INT_SHUT] = hitNow && scanEntry.shutEn;
    intSet[fac_pkg::INT_DENY] = hitNow && scanEntry.deny;
    intSet[fac_pkg::INT_LOG_LOST] = logWant && !logGo;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      intStat <= '0;
    else if (regWrite && regAddr == fac_pkg::OFF_INT_STAT)
      intStat <= (intStat & ~regWdata[fac_pkg::INT_W-1:0]) | intSet;
    else
      intStat <= intStat | intSet;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      intMask <= fac_pkg::RST_MASK;
    else if (regWrite && regAddr == fac_pkg::OFF_INT_MASK)
      intMask <= regWdata[fac_pkg::INT_W-1:0];
  end

  assign irq = |(intStat & intMask);

  // ==========================================
  // register read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      regRdata <= '0;
    else if (!regRead)
      regRdata <= '0;
    else if (rdSlot != 4'hf)
      regRdata <= stage[rdSlot[2:0]];
    else
    begin
      case (regAddr)
        fac_pkg::OFF_CTRL: regRdata <= 32'(state != fac_pkg::FAC_ST_IDLE) << fac_pkg::CTRL_BUSY;
        fac_pkg::OFF_SEL: regRdata <= 32'(entrySel);
        fac_pkg::OFF_HITS: regRdata <= selCount;
        fac_pkg::OFF_INT_STAT: regRdata <= 32'(intStat);
        fac_pkg::OFF_INT_MASK: regRdata <= 32'(intMask);
        fac_pkg::OFF_PORT_SHUT: regRdata <= portShut;
        fac_pkg::OFF_LAST: regRdata <= 32'(lastInfo) << fac_pkg::LAST_IDX;
        default: regRdata <= 32'h0;
      endcase
    end
  end
endmodule // fac_classifier

// >>> fac_classifier_properties.sv
`timescale 1ns/1ps
module fac_classifier_properties
(
  // clock and reset
  input logic clock,
  input logic rst,
  // watched ports
  input logic frmValid,
  input logic frmReady,
  input logic resValid,
  input fac_pkg::fac_result_s res,
  input logic logValid,
  input logic [fac_pkg::NUM_PORTS-1:0] portShut
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  int gap;
  // ==========================================
  // cycles since the last log
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gap <= fac_pkg::LOG_GAP_CYC;
    else if (logValid)
      gap <= 0;
    else if (gap < fac_pkg::LOG_GAP_CYC)
      gap <= gap + 1;
  end
  take_blocks_a: assert property (frmValid && frmReady |=> !frmReady)
    else $error("frame taken while busy");
  verdict_bound_a: assert property (frmValid && frmReady |-> ##[2:129] resValid)
    else $error("verdict late");
  ready_back_a: assert property (resValid |-> !frmReady ##1 frmReady)
    else $error("ready not restored");
  drop_hit_a: assert property (resValid && res.drop |-> res.hit)
    else $error("drop without hit");
  miss_clean_a: assert property (resValid && !res.hit |-> !res.drop && !res.copyEn && !res.log && !res.shut
    && res.rateSel == 4'h0)
    else $error("miss carries actions");
  copy_hit_a: assert property (resValid && res.copyEn |-> res.hit)
    else $error("copy without hit");
  shut_port_a: assert property (resValid && res.shut |-> ##[0:1] portShut[res.port])
    else $error("port not shut");
  log_verdict_a: assert property (logValid |-> resValid && res.hit && res.log)
    else $error("log without logged hit");
  log_gap_a: assert property (logValid |-> gap >= fac_pkg::LOG_GAP_CYC - 1)
    else $error("logs too close");
  res_hold_a: assert property (!resValid |-> $stable(res))
    else $error("result moved");
endmodule // fac_classifier_properties
bind fac_classifier fac_classifier_properties chk (.clock(clock), .rst(rst), .frmValid(frmValid),
  .frmReady(frmReady), .resValid(resValid), .res(res), .logValid(logValid), .portShut(portShut));

// >>> fac_entry_match.sv
`timescale 1ns/1ps
module fac_entry_match
(
  // entry under test
  input logic valid,
  input fac_pkg::fac_entry_s entry,
  // frame
  input fac_pkg::fac_frame_s frame,
  // verdict
  output logic hit
);
  logic scopeOk;
  logic typeOk;
  logic srcOk;
  logic dstOk;
  logic vlanOk;
  logic prioOk;
  logic isGroup;
  logic isAll;

  // ==========================================
  // field checks
  always_comb
  begin
    isGroup = frame.dstAddr[40];
    isAll = &frame.dstAddr;
    case (entry.scope)
      fac_pkg::FAC_SCOPE_ANY: scopeOk = 1'b1;
      fac_pkg::FAC_SCOPE_PORT: scopeOk = frame.port == entry.scopeVal;
      fac_pkg::FAC_SCOPE_POLICY: scopeOk = frame.policy == entry.scopeVal[3:0] && frame.policy != 4'h0;
      default: scopeOk = 1'b0;
    endcase
    typeOk = entry.ftype == fac_pkg::FAC_FT_ANY || entry.ftype == frame.kind;
    // source filter only for ethertype or arp
    srcOk = !entry.srcSpecific || !(entry.ftype == fac_pkg::FAC_FT_ETYPE || entry.ftype == fac_pkg::FAC_FT_ARP) ||
      frame.srcAddr == entry.sourceStationAddress;
    case (entry.dstFilter)
      fac_pkg::FAC_DA_ANY: dstOk = 1'b1;
      fac_pkg::FAC_DA_GROUP: dstOk = isGroup && !isAll;
      fac_pkg::FAC_DA_ALL: dstOk = isAll;
      fac_pkg::FAC_DA_SINGLE: dstOk = !isGroup;
      fac_pkg::FAC_DA_SPECIFIC: dstOk = frame.dstAddr == entry.destinationStationAddress;
      default: dstOk = 1'b0;
    endcase
    vlanOk = !entry.vlanSpecific || (entry.vid != 12'h0 && frame.vid == entry.vid);
    prioOk = entry.prioAny || frame.prio == entry.prio;
    hit = valid && scopeOk && typeOk && srcOk && dstOk && vlanOk && prioOk;
  end
endmodule // fac_entry_match

// >>> fac_hit_count.sv
`timescale 1ns/1ps
module fac_hit_count
(
  // clock and reset
  input logic clock,
  input logic rst,
  // update
  input logic incEn,
  input logic [fac_pkg::IDX_W-1:0] incIdx,
  input logic clrAll,
  // read
  input logic [fac_pkg::IDX_W-1:0] rdIdx,
  output logic [fac_pkg::CNT_W-1:0] rdCount
);
  logic [fac_pkg::CNT_W-1:0] count [fac_pkg::NUM_ENTRIES];

  assign rdCount = count[rdIdx];

  // ==========================================
  // per entry counters
  genvar g;
  generate
    for (g = 0; g < fac_pkg::NUM_ENTRIES; g++)
    begin : gCnt
      always_ff @(posedge clock or posedge rst)
      begin
        if (rst)
          count[g] <= '0;
        // count each hit, clear then count
        else if (incEn && incIdx == fac_pkg::IDX_W'(g))
          count[g] <= (clrAll ? '0 : count[g]) + 32'h1;
        else if (clrAll)
          count[g] <= '0;
      end
    end
  endgenerate
endmodule // fac_hit_count

// >>> fac_pkg.sv
package fac_pkg;
  // ==========================================
  // sizes
  localparam int NUM_ENTRIES = 128;
  localparam int IDX_W = 7;
  localparam int PORT_W = 5;
  localparam int NUM_PORTS = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 32;
  localparam int NUM_CFG = 6;
  localparam int INT_W = 4;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SEL = 8'h04;
  localparam logic [7:0] OFF_CFG0 = 8'h08;
  localparam logic [7:0] OFF_HITS = 8'h20;
  localparam logic [7:0] OFF_INT_STAT = 8'h24;
  localparam logic [7:0] OFF_INT_MASK = 8'h28;
  localparam logic [7:0] OFF_PORT_SHUT = 8'h2c;
  localparam logic [7:0] OFF_LAST = 8'h30;
  // ==========================================
  // control bits
  localparam int CTRL_COMMIT = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_CLR_CNT = 2;
  localparam int CTRL_REMOVE_ALL = 3;
  localparam int CTRL_BUSY = 4;
  // interrupt status bits
  localparam int INT_LOGGED = 0;
  localparam int INT_SHUT = 1;
  localparam int INT_DENY = 2;
  localparam int INT_LOG_LOST = 3;
  // last result fields
  localparam int LAST_IDX = 0;
  localparam int LAST_HIT = 8;
  // ==========================================
  // config word 0 field positions
  localparam int POS_VALID = 0;
  localparam int POS_SCOPE = 1;
  localparam int POS_SCOPE_VAL = 3;
  localparam int POS_FTYPE = 8;
  localparam int POS_DENY = 10;
  localparam int POS_RATE = 11;
  localparam int POS_COPY_EN = 15;
  localparam int POS_COPY_PORT = 16;
  localparam int POS_LOG = 21;
  localparam int POS_SHUT = 22;
  localparam int POS_SRC_SPEC = 23;
  localparam int POS_DST_FILT = 24;
  localparam int POS_VLAN_SPEC = 27;
  localparam int POS_PRIO_ANY = 28;
  localparam int POS_PRIO = 29;
  // config word 1 field position
  localparam int POS_VID = 0;
  // ==========================================
  // reset values
  localparam logic [31:0] RST_CFG = 32'h0;
  localparam logic [INT_W-1:0] RST_MASK = 4'h0;
  localparam logic [IDX_W-1:0] RST_SEL = 7'h0;
  // ==========================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int LOG_GAP_US = 50;
  localparam int LOG_GAP_CYC = (LOG_GAP_US * CLK_HZ + 999999) / 1000000;
  localparam int GAP_W = 11;
  // ==========================================
  // types
  typedef enum logic [1:0] {FAC_SCOPE_ANY = 2'h0, FAC_SCOPE_PORT = 2'h1, FAC_SCOPE_POLICY = 2'h2} fac_scope_e;
  typedef enum logic [1:0] {FAC_FT_ANY = 2'h0, FAC_FT_ETYPE = 2'h1, FAC_FT_ARP = 2'h2, FAC_FT_IPV4 = 2'h3} fac_ftype_e;
  typedef enum logic [2:0] {
    FAC_DA_ANY = 3'h0,
    FAC_DA_GROUP = 3'h1,
    FAC_DA_ALL = 3'h2,
    FAC_DA_SINGLE = 3'h3,
    FAC_DA_SPECIFIC = 3'h4
  } fac_dafilt_e;
  typedef enum logic [2:0] {FAC_ST_IDLE = 3'h1, FAC_ST_SCAN = 3'h2, FAC_ST_DONE = 3'h4} fac_state_e;
  typedef logic [NUM_CFG-1:0][31:0] fac_words_t;

  typedef struct packed {
    fac_scope_e scope;
    logic [PORT_W-1:0] scopeVal;
    fac_ftype_e ftype;
    logic deny;
    logic [3:0] rateSel;
    logic copyEn;
    logic [PORT_W-1:0] copyPort;
    logic logEn;
    logic shutEn;
    logic srcSpecific;
    logic [47:0] sourceStationAddress;
    fac_dafilt_e dstFilter;
    logic [47:0] destinationStationAddress;
    logic vlanSpecific;
    logic [11:0] vid;
    logic prioAny;
    logic [2:0] prio;
  } fac_entry_s;

  // kind uses the frame type codes, with 0 meaning none of them
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [3:0] policy;
    fac_ftype_e kind;
    logic [47:0] srcAddr;
    logic [47:0] dstAddr;
    logic [11:0] vid;
    logic [2:0] prio;
  } fac_frame_s;

  typedef struct packed {
    logic hit;
    logic [IDX_W-1:0] index;
    logic drop;
    logic [3:0] rateSel;
    logic copyEn;
    logic [PORT_W-1:0] copyPort;
    logic log;
    logic shut;
    logic [PORT_W-1:0] port;
  } fac_result_s;
endpackage

// >>> fac_rx_source.sv
`timescale 1ns/1ps
module fac_rx_source
(
  // clock and reset
  input logic clock,
  input logic rst,
  // request from bench
  input logic go,
  input logic [3:0] dly,
  input fac_pkg::fac_frame_s goFrm,
  // frame port
  input logic frmReady,
  output logic frmValid,
  output fac_pkg::fac_frame_s frm
);
  logic pend;
  logic [3:0] wt;
  // ==========================================
  // hold descriptor until taken, then scramble it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      wt <= 4'h0;
      frmValid <= 1'b0;
      frm <= '0;
    end
    else
    begin
      if (go)
      begin
        pend <= 1'b1;
        wt <= dly;
        frm <= goFrm;
      end
      else if (pend && wt != 4'h0)
        wt <= wt - 4'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        frmValid <= 1'b1;
      end
      if (frmValid && frmReady)
      begin
        frmValid <= 1'b0;
        frm <= ~frm;
      end
    end
  end
endmodule // fac_rx_source

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic go = 1'b0;
  logic [3:0] dly = 4'h0;
  fac_pkg::fac_frame_s goFrm = '0;
  logic [31:0] regRdata, portShut, lf, shutM, d, c0;
  logic frmValid, frmReady, resValid, logValid, irq;
  logic [6:0] logIndex;
  fac_pkg::fac_frame_s frm;
  fac_pkg::fac_result_s res;
  logic [31:0] mc[128] = '{default: 32'h0};
  logic [11:0] mv[128];
  logic [47:0] ms[128], md[128];
  int cnt[128] = '{default: 0};
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat = 0;
  int lastLog = -fac_pkg::LOG_GAP_CYC;
  fac_classifier dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .frmValid(frmValid), .frmReady(frmReady), .frm(frm),
    .resValid(resValid), .res(res), .logValid(logValid), .logIndex(logIndex), .portShut(portShut), .irq(irq));
  fac_rx_source src (.clock(clock), .rst(rst), .go(go), .dly(dly), .goFrm(goFrm), .frmReady(frmReady),
    .frmValid(frmValid), .frm(frm));
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    lat <= (frmValid && frmReady) ? 0 : lat + 1;
    if (cyc > 60000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task put(input int i, input logic [31:0] c, input logic [11:0] v, input logic [47:0] s, input logic [47:0] t);
    wr(fac_pkg::OFF_SEL, 32'(i));
    wr(fac_pkg::OFF_CFG0, c);
    wr(8'h0c, {20'h0, v});
    wr(8'h10, s[31:0]);
    wr(8'h14, {16'h0, s[47:32]});
    wr(8'h18, t[31:0]);
    wr(8'h1c, {16'h0, t[47:32]});
    wr(fac_pkg::OFF_CTRL, 32'h1);
    mc[i] = c;
    mv[i] = v;
    ms[i] = s;
    md[i] = t;
  endtask
  function automatic fac_pkg::fac_frame_s mkFrm(input logic [31:0] r);
    fac_pkg::fac_frame_s f;
    f.port = {3'h0, r[1:0]};
    f.policy = {2'h0, r[3:2]};
    f.kind = fac_pkg::fac_ftype_e'(r[5:4]);
    f.srcAddr = 48'h0a0b0c0d0e0f ^ {47'h0, r[6]};
    case (r[8:7])
      2'h0: f.dstAddr = 48'h0a0000000001;
      2'h1: f.dstAddr = 48'h01005e000001;
      2'h2: f.dstAddr = 48'hffffffffffff;
      default: f.dstAddr = 48'h02aa00000002;
    endcase
    f.vid = r[10] ? 12'h005 : {11'h0, r[9]};
    f.prio = r[13:11];
    return f;
  endfunction
  function automatic int hitOf(input fac_pkg::fac_frame_s f);
    logic [31:0] c;
    logic [47:0] a;
    a = f.dstAddr;
    for (int i = 0; i < 128; i++)
    begin
      c = mc[i];
      if (c[0] && (c[2:1] != 2'h1 || f.port == c[7:3])
        && (c[2:1] != 2'h2 || (f.policy != 4'h0 && {1'b0, f.policy} == c[7:3]))
        && (c[9:8] == 2'h0 || f.kind == c[9:8]) && (!c[23] || c[9] == c[8] || f.srcAddr == ms[i])
        && (c[26:24] != 3'h1 || (a[40] && !(&a))) && (c[26:24] != 3'h2 || (&a))
        && (c[26:24] != 3'h3 || !a[40]) && (c[26:24] != 3'h4 || a == md[i])
        && (!c[27] || (mv[i] != 12'h0 && f.vid == mv[i])) && (c[28] || f.prio == c[31:29]))
        return i;
    end
    return 128;
  endfunction
  task frame(input fac_pkg::fac_frame_s f);
    int k;
    int n;
    logic [31:0] c;
    logic e;
    k = hitOf(f);
    c = (k < 128) ? mc[k] : 32'h0;
    @(posedge clock);
    go <= 1'b1;
    goFrm <= f;
    dly <= lf[3:0];
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    while (n < 300 && resValid !== 1'b1)
    begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 300)
      bad_count++;
    chk(64'(lat), (k < 128) ? 64'(k + 1) : 64'h80);
    chk({res.hit, res.index, res.drop, res.rateSel, res.copyEn, res.copyPort & {5{res.copyEn}}, res.log,
      res.shut, res.port}, {k < 128, (k < 128) ? 7'(k) : 7'h0, c[10], c[14:11], c[15], c[20:16] & {5{c[15]}},
      c[21], c[22], f.port});
    e = k < 128 && c[21] && cyc - lastLog >= fac_pkg::LOG_GAP_CYC;
    if (e)
      lastLog = cyc;
    chk({logValid, logValid ? logIndex : 7'h0}, {e, e ? 7'(k) : 7'h0});
    if (k < 128)
      cnt[k]++;
    if (k < 128 && c[22])
      shutM[f.port] = 1'b1;
    @(posedge clock);
    #1 chk(portShut, shutM);
    lf = nxt(lf);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    lf = 32'h00015cc8;
    shutM = 32'h0;
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(fac_pkg::OFF_INT_MASK, d);
    chk(d, 32'h0);
    rd(8'h3c, d);
    chk(d, 32'h0);
    frame(mkFrm(lf));
    put(127, 32'h10000001, 12'h0, 48'h0, 48'h0);
    frame(mkFrm(lf));
    put(0, 32'h10000401, 12'h0, 48'h0, 48'h0);
    frame(mkFrm(lf));
    rd(fac_pkg::OFF_INT_STAT, d);
    chk(d & 32'h4, 32'h4);
    chk(irq, 1'b0);
    wr(fac_pkg::OFF_INT_MASK, 32'h4);
    #1 chk(irq, 1'b1);
    wr(fac_pkg::OFF_INT_STAT, 32'h4);
    #1 chk(irq, 1'b0);
    // ==========================================
    // random entries in front of the catch-all
    for (int i = 0; i < 7; i++)
    begin
      lf = nxt(lf);
      c0 = lf;
      lf = nxt(lf);
      c0 = c0 & ~(lf & 32'h0f800306);
      c0[0] = 1'b1;
      c0[7:5] = 3'h0;
      if (c0[2:1] == 2'h3)
        c0[2] = 1'b0;
      if (c0[26:24] > 3'h4)
        c0[26] = 1'b0;
      put(i, c0, lf[9] ? 12'h005 : 12'h000, 48'h0a0b0c0d0e0f, 48'h0a0000000001);
    end
    for (int n = 0; n < 100; n++)
      frame(mkFrm(lf));
    for (int i = 0; i < 9; i++)
    begin
      wr(fac_pkg::OFF_SEL, (i < 8) ? 32'(i) : 32'h7f);
      rd(fac_pkg::OFF_HITS, d);
      chk(d, 32'(cnt[(i < 8) ? i : 127]));
    end
    wr(fac_pkg::OFF_CTRL, 32'h4);
    rd(fac_pkg::OFF_HITS, d);
    chk(d, 32'h0);
    wr(fac_pkg::OFF_SEL, 32'h0);
    wr(fac_pkg::OFF_CTRL, 32'h2);
    rd(fac_pkg::OFF_CFG0, d);
    chk(d, mc[0]);
    wr(fac_pkg::OFF_CTRL, 32'h8);
    wr(fac_pkg::OFF_CTRL, 32'h2);
    rd(fac_pkg::OFF_CFG0, d);
    chk(d, mc[0] & 32'hfffffffe);
    mc = '{default: 32'h0};
    frame(mkFrm(lf));
    rd(fac_pkg::OFF_LAST, d);
    chk(d, 32'h7f);
    wr(fac_pkg::OFF_PORT_SHUT, 32'hffffffff);
    #1 chk(portShut, 32'h0);
    give_verdict();
  end
endmodule // tb_top
